// [verilog/bit_test_skip_exec.v]
// Execution of the two bit-test-and-skip instructions over four phases
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_skip_defs.vh"
// Notes on behaviour
// RULE_01 - Opcode b: skip next when bit clear
// RULE_02 - Opcode a: skip next when bit set
// RULE_03 - Skip discards prefetch, runs NOP, two cycles
// RULE_04 - a=0 uses access bank, else bank_selector
// RULE_05 - No write-back, no flags change
module bit_test_skip_exec #(
	parameter AW = 12,
	parameter DEPTH = 4096
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Instruction from fetch, valid at phase Q1
	input wire instr_valid,
	input wire [15:0] instr_word,
	// Bank selector value
	input wire [3:0] bank_selector,
	// Preload port for the data memory
	input wire load_en,
	input wire [AW-1:0] load_addr,
	input wire [7:0] load_data,
	// Results
	output reg [1:0] phase,
	output reg busy,
	output reg [AW-1:0] eff_addr,
	output reg tested_bit,
	output reg skip_taken,
	output reg flush_prefetch,
	output reg [15:0] exec_word,
	output reg cycle_done,
	output wire reg_write,
	output wire status_write
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function [AW-1:0] resolve_addr;
		input access;
		input [7:0] f;
		input [3:0] bank;
		begin
			if (!access) begin
				resolve_addr = (f < `ACCESS_SPLIT) ? {`ACCESS_LO_BANK, f} : {`ACCESS_HI_BANK, f}; // RULE_04
			end else begin
				resolve_addr = {bank, f}; // RULE_04
			end
		end
	endfunction

	// Phase counter step, shared by the execute and filler cycles
	function [1:0] next_phase;
		input [1:0] ph;
		begin
			next_phase = ph + 2'h1;
		end
	endfunction

	localparam ST_IDLE = 2'h0;
	localparam ST_EXEC = 2'h1;
	localparam ST_NOP = 2'h2;

	// ----------------------------------------
	// State and decode
	// ----------------------------------------
	reg [1:0] state_q;
	reg [15:0] ir_q;
	reg [1:0] state_d;
	reg [1:0] phase_d;
	reg take_w;
	reg decide_w;
	reg nop_end_w;
	// Read data comes straight from the memory's output register
	wire [7:0] rd_data;
	wire read_strobe = (state_q == ST_EXEC) && (phase == `PHASE_Q2);
	wire [3:0] opc = ir_q[`OPC_HI:`OPC_LO];
	wire is_clear = (opc == `OPC_SKIP_IF_CLEAR);
	wire is_set = (opc == `OPC_SKIP_IF_SET);
	wire [2:0] bsel = ir_q[`FLD_BIT_HI:`FLD_BIT_LO];
	wire [AW-1:0] addr_w = resolve_addr(ir_q[`FLD_ACCESS], ir_q[`FLD_ADDR_HI:`FLD_ADDR_LO], bank_selector);
	wire bit_w = rd_data[bsel];
	wire skip_w = (is_clear & ~bit_w) | (is_set & bit_w); // RULE_01 RULE_02

	// ----------------------------------------
	// Fixed outputs
	// ----------------------------------------
	// Memory is only read by this unit; the preload port is its sole writer
	assign reg_write = 1'b0; // RULE_05
	assign status_write = 1'b0; // RULE_05

	// ----------------------------------------
	// Data memory
	// ----------------------------------------
	data_reg_file #(.AW(AW), .DEPTH(DEPTH)) u_mem (
		.mclk(mclk),
		.wr_en(load_en),
		.wr_addr(load_addr),
		.wr_data(load_data),
		.rd_en(read_strobe),
		.rd_addr(addr_w),
		.rd_data(rd_data)
	);

	// ----------------------------------------
	// Next phase and state
	// ----------------------------------------
	// Idle parks the phase at Q1 so that the take edge always starts a fresh Q2
	always @* begin
		state_d = state_q;
		phase_d = phase;
		take_w = 1'b0;
		decide_w = 1'b0;
		nop_end_w = 1'b0;
		case (state_q)
			ST_IDLE: begin
				phase_d = `PHASE_Q1;
				if (instr_valid) begin
					take_w = 1'b1;
					phase_d = `PHASE_Q2;
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				phase_d = next_phase(phase);
				if (phase == `PHASE_Q4) begin
					// Q4 leaves memory alone; only the skip decision is made here
					decide_w = 1'b1;
					state_d = skip_w ? ST_NOP : ST_IDLE; // RULE_03
				end
			end
			ST_NOP: begin
				// Second cycle spent on the discarded slot
				phase_d = next_phase(phase);
				if (phase == `PHASE_Q4) begin
					nop_end_w = 1'b1; // RULE_03
					state_d = ST_IDLE;
				end
			end
			default: begin
				phase_d = `PHASE_Q1;
				state_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Phase and state registers
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			phase <= `PHASE_Q1;
		end else begin
			state_q <= state_d;
			phase <= phase_d;
		end
	end

	// ----------------------------------------
	// Instruction latch
	// ----------------------------------------
	// exec_word shows the filler word once the prefetched slot is dropped
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q <= 16'h0000;
			exec_word <= 16'h0000;
		end else if (take_w) begin
			ir_q <= instr_word;
			exec_word <= instr_word;
		end else if (decide_w && skip_w) begin
			exec_word <= `NOP_WORD; // RULE_03
		end
	end

	// ----------------------------------------
	// Operand capture
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			eff_addr <= {AW{1'b0}};
			tested_bit <= 1'b0;
		end else begin
			if (read_strobe) begin
				eff_addr <= addr_w; // RULE_04
			end
			if (state_q == ST_EXEC && phase == `PHASE_Q3) begin
				tested_bit <= bit_w;
			end
		end
	end

	// ----------------------------------------
	// Decision, busy and pulses
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_taken <= 1'b0;
			flush_prefetch <= 1'b0;
			cycle_done <= 1'b0;
			busy <= 1'b0;
		end else begin
			flush_prefetch <= decide_w & skip_w; // RULE_03
			cycle_done <= decide_w | nop_end_w; // RULE_03
			if (take_w) begin
				skip_taken <= 1'b0;
				busy <= 1'b1;
			end else if (decide_w) begin
				// Busy stays up through the filler cycle when the slot is dropped
				skip_taken <= skip_w; // RULE_01 RULE_02
				busy <= skip_w;
			end else if (nop_end_w) begin
				busy <= 1'b0;
			end
		end
	end
endmodule // bit_test_skip_exec
`default_nettype wire

// [verilog/bit_test_skip_defs.vh]
// Constants for the bit test and skip execution unit
`ifndef BIT_TEST_SKIP_DEFS_VH
`define BIT_TEST_SKIP_DEFS_VH
`define OPC_SKIP_IF_CLEAR 4'hb
`define OPC_SKIP_IF_SET 4'ha
`define OPC_HI 15
`define OPC_LO 12
`define FLD_BIT_HI 11
`define FLD_BIT_LO 9
`define FLD_ACCESS 8
`define FLD_ADDR_HI 7
`define FLD_ADDR_LO 0
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hf
`define ACCESS_LO_BANK 4'h0
`define BANK_RESET 4'h0
`define NOP_WORD 16'hf000
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3
`endif

// [verilog/data_reg_file.v]
// Small banked data memory with a registered read port
`timescale 1ns/1ps
`default_nettype none
module data_reg_file #(
	parameter AW = 12,
	parameter DEPTH = 4096
) (
	// Clock
	input wire mclk,
	// Write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [7:0] wr_data,
	// Read port
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:DEPTH-1];

	always @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // data_reg_file
`default_nettype wire

// [test/instr_feeder.sv]
// Fetch side model offering one word at a time
`timescale 1ns/1ps
`default_nettype none
module instr_feeder (
	// Clock
	input wire logic mclk,
	// Handshake from the unit and the bench
	input wire logic busy,
	input wire logic go,
	input wire logic [15:0] word,
	// Word offered to the unit
	output var logic instr_valid = 1'b0,
	output var logic [15:0] instr_word = 16'h0000
);
	always @(posedge mclk) begin
		if (go) begin
			instr_valid <= 1'b1;
			instr_word <= word;
		end else if (instr_valid && !busy) begin
			instr_valid <= 1'b0;
			// Inverted once taken so a late sample never passes
			instr_word <= ~word;
		end
	end
endmodule // instr_feeder
`default_nettype wire

// [test/skip_monitor.sv]
// Assertions for the bit test and skip unit
`timescale 1ns/1ps
`default_nettype none
module skip_monitor #(
	parameter int AW = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bank selector seen by the unit
	input wire logic [3:0] bank_selector,
	// Unit outputs
	input wire logic [1:0] phase,
	input wire logic busy,
	input wire logic [AW-1:0] eff_addr,
	input wire logic tested_bit,
	input wire logic skip_taken,
	input wire logic flush_prefetch,
	input wire logic [15:0] exec_word,
	input wire logic cycle_done,
	input wire logic reg_write,
	input wire logic status_write
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_clear_skip: assert property (busy && phase == 2'h3 && exec_word[15:12] == 4'hb |=>
		skip_taken == !$past(tested_bit)) else $error("clear");
	a_set_skip: assert property (busy && phase == 2'h3 && exec_word[15:12] == 4'ha |=>
		skip_taken == $past(tested_bit)) else $error("set");
	a_nop_fill: assert property (flush_prefetch |-> exec_word == 16'hf000 ##4 cycle_done) else $error("nop");
	a_bank_pick: assert property (busy && phase == 2'h2 && exec_word[15:13] == 3'h5 |-> eff_addr ==
		(exec_word[8] ? {bank_selector, exec_word[7:0]} : {{4{exec_word[7]}}, exec_word[7:0]})) else $error("bank");
	a_no_write: assert property (!reg_write && !status_write) else $error("write");
	a_phase_walk: assert property (busy |=> phase == 2'($past(phase) + 2'h1)) else $error("phase");
	a_flush_pulse: assert property (flush_prefetch |=> !flush_prefetch && busy) else $error("flush");
endmodule // skip_monitor
bind bit_test_skip_exec skip_monitor #(.AW(AW)) u_skip_monitor (
	.mclk(mclk),
	.rst_n(rst_n),
	.bank_selector(bank_selector),
	.phase(phase),
	.busy(busy),
	.eff_addr(eff_addr),
	.tested_bit(tested_bit),
	.skip_taken(skip_taken),
	.flush_prefetch(flush_prefetch),
	.exec_word(exec_word),
	.cycle_done(cycle_done),
	.reg_write(reg_write),
	.status_write(status_write)
);
`default_nettype wire

// [test/bit_test_skip_exec_test.sv]
// Random and corner tests of the skip unit
`timescale 1ns/1ps
`default_nettype none
module bit_test_skip_exec_test;
	reg mclk = 0, rst_n = 0, go = 0, load_en = 0, sk;
	reg [15:0] word = 0, w;
	reg [11:0] load_addr = 0;
	reg [7:0] load_data = 0, d;
	reg [3:0] bank_selector = 0;
	wire instr_valid, busy, tested_bit, skip_taken, flush_prefetch, cycle_done, reg_write, status_write;
	wire [15:0] instr_word, exec_word;
	wire [11:0] eff_addr;
	wire [1:0] phase;
	integer mismatches = 0, total_checks = 0, i, n;
	bit_test_skip_exec u_bit_test_skip_exec (
		.mclk(mclk),
		.rst_n(rst_n),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.bank_selector(bank_selector),
		.load_en(load_en),
		.load_addr(load_addr),
		.load_data(load_data),
		.phase(phase),
		.busy(busy),
		.eff_addr(eff_addr),
		.tested_bit(tested_bit),
		.skip_taken(skip_taken),
		.flush_prefetch(flush_prefetch),
		.exec_word(exec_word),
		.cycle_done(cycle_done),
		.reg_write(reg_write),
		.status_write(status_write)
	);
	instr_feeder u_instr_feeder (
		.mclk(mclk),
		.busy(busy),
		.go(go),
		.word(word),
		.instr_valid(instr_valid),
		.instr_word(instr_word)
	);
	initial forever #50 mclk = ~mclk;
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		conclude;
	end
	function [11:0] addr_of(input [15:0] iw, input [3:0] bs);
		addr_of = iw[8] ? {bs, iw[7:0]} : {{4{iw[7]}}, iw[7:0]};
	endfunction
	task chk(input [16:0] g, e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %h %h", $time, g, e);
		end
	endtask
	task step;
		do begin
			@(posedge mclk);
			go <= 0;
			#1 n++;
		end while (cycle_done !== 1'h1 && n < 12);
	endtask
	task conclude;
		$display("mismatches %0d total_checks %0d", mismatches, total_checks);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hfe7e));
		repeat (6) @(posedge mclk);
		rst_n <= 1;
		for (i = 0; i < 40; i++) begin
			w = {i % 5 == 4 ? 3'h4 : 3'h5, 13'($urandom)};
			// Access bank edges on the top bit
			if (i < 4) w[11:0] = {4'he, i[1] ? 8'h80 : 8'h7f};
			d = $urandom;
			@(posedge mclk);
			bank_selector <= $urandom;
			@(posedge mclk);
			load_en <= 1;
			load_addr <= addr_of(w, bank_selector);
			load_data <= d;
			@(posedge mclk);
			load_en <= 0;
			go <= 1;
			word <= w;
			sk = w[15:12] == 4'hb ? !d[w[11:9]] : w[15:12] == 4'ha && d[w[11:9]];
			n = 0;
			step;
			chk({skip_taken, exec_word}, {sk, sk ? 16'hf000 : w});
			if (w[13]) chk({eff_addr, tested_bit}, {addr_of(w, bank_selector), d[w[11:9]]});
			if (sk) step;
			chk(n, sk ? 9 : 5);
			if (i % 3 == 0) begin
				// Run the word again with no preload: the tested register must be untouched
				@(posedge mclk);
				go <= 1;
				n = 0;
				step;
				chk({skip_taken, tested_bit, reg_write, status_write}, {sk, d[w[11:9]], 2'h0});
				if (sk) step;
			end
			$display("test %0d done", i);
		end
		conclude;
	end
endmodule // bit_test_skip_exec_test
`default_nettype wire
